/* File: core/dalg_top.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// alert, parity latency and internal timing of the memory device
// ---------------------------------------------------------------------------
// Summary of operation
// - parity latency is 6 clocks; commands near a parity error may be dropped.
// - parity error raises alert within parity latency plus 6 ns.
// - parity alert lasts 88 to 176 clocks, or 96 to 192 at faster bin.
// - write crc error raises alert between 3 ns and 13 ns later.
// - crc alert pulse lasts 6 to 10 clocks, shorter than parity alert.
// - internal write starts 4 clocks after write latency, 2 for fixed chop-4.
// - clock enable may drop during row or refresh work; low power follows completion.
module dalg_top
    import dalg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // device pins
    input wire logic ck,
    input wire logic cke,
    input wire logic [7:0] ca,
    input wire logic ca_par,
    output logic alert_n,
    // write data path
    input wire logic wr_crc_err,
    // executed commands and internal events
    output logic exec_valid,
    output dalg_pkg::dalg_cmd_e exec_cmd,
    output logic wr_start,
    output logic pdown
);
    import dalg_pkg::*;

    // -----------------------------------------------------------------------
    // pin synchronisation and clock edge detection
    // -----------------------------------------------------------------------
    logic ck_s;
    logic cke_s;
    logic par_s;
    logic [7:0] ca_s;
    logic ck_d;
    logic ck_rise;

    // the bus is held stable around the clock edge, so the pins may share one pass
    dalg_sync #(.WIDTH(11)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .din({ck, cke, ca_par, ca}),
        .dout({ck_s, cke_s, par_s, ca_s})
    );

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ck_d <= 1'b0;
        else
            ck_d <= ck_s;
    end

    assign ck_rise = ck_s & ~ck_d;

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    logic [5:0] ctrl;
    logic [4:0] wlat;
    logic st_par;
    logic st_crc;
    logic [15:0] par_cnt;
    logic [15:0] crc_cnt;
    logic [31:0] rdata;
    logic [5:0] next_ctrl;
    logic [4:0] next_wlat;
    logic next_st_par;
    logic next_st_crc;
    logic [15:0] next_par_cnt;
    logic [15:0] next_crc_cnt;
    logic [31:0] next_rdata;
    logic par_en;
    logic crc_en;
    logic par_trig;
    logic crc_trig;
    logic par_act;
    logic crc_act;
    logic busy;

    assign par_en = ctrl[CTRL_PAR_EN];
    assign crc_en = ctrl[CTRL_CRC_EN];

    // writes, sticky errors with set over clear, read mux
    always_comb
    begin
        next_ctrl = ctrl;
        next_wlat = wlat;
        next_st_par = st_par;
        next_st_crc = st_crc;
        next_par_cnt = par_cnt;
        next_crc_cnt = crc_cnt;
        next_rdata = 32'h0000_0000;
        if (reg_wr && reg_addr == REG_CTRL)
            next_ctrl = reg_wdata[5:0];
        if (reg_wr && reg_addr == REG_WLAT)
            next_wlat = reg_wdata[4:0];
        if (reg_wr && reg_addr == REG_STATUS)
        begin
            if (reg_wdata[ST_PAR_ERR])
                next_st_par = 1'b0;
            if (reg_wdata[ST_CRC_ERR])
                next_st_crc = 1'b0;
        end
        if (reg_wr && reg_addr == REG_ERRCNT)
        begin
            next_par_cnt = 16'h0000;
            next_crc_cnt = 16'h0000;
        end
        if (par_trig)
        begin
            next_st_par = 1'b1;
            next_par_cnt = par_cnt + 16'h0001;
        end
        if (crc_trig)
        begin
            next_st_crc = 1'b1;
            next_crc_cnt = crc_cnt + 16'h0001;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL: next_rdata = {26'h0, ctrl};
                REG_WLAT: next_rdata = {27'h0, wlat};
                REG_STATUS: next_rdata = {27'h0, pdown, busy, ~alert_n, st_crc, st_par};
                REG_ERRCNT: next_rdata = {crc_cnt, par_cnt};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl <= CTRL_RST;
            wlat <= WLAT_RST;
            st_par <= 1'b0;
            st_crc <= 1'b0;
            par_cnt <= 16'h0000;
            crc_cnt <= 16'h0000;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            wlat <= next_wlat;
            st_par <= next_st_par;
            st_crc <= next_st_crc;
            par_cnt <= next_par_cnt;
            crc_cnt <= next_crc_cnt;
            rdata <= next_rdata;
        end
    end

    assign reg_rdata = rdata;

    // -----------------------------------------------------------------------
    // parity latency pipeline
    // -----------------------------------------------------------------------
    logic [PL_NCK-1:0] pipe_vld;
    logic [PL_NCK-1:0] pipe_err;
    logic [3*PL_NCK-1:0] pipe_cmd;
    logic [2:0] blk_cnt;
    logic [PL_NCK-1:0] next_pipe_vld;
    logic [PL_NCK-1:0] next_pipe_err;
    logic [3*PL_NCK-1:0] next_pipe_cmd;
    logic [2:0] next_blk_cnt;
    logic next_exec_valid;
    dalg_cmd_e next_exec_cmd;
    dalg_cmd_e in_cmd;
    logic in_vld;
    logic err_now;

    assign in_cmd = dalg_cmd_e'(ca_s[2:0]);
    assign in_vld = (in_cmd != CMD_DES) && (in_cmd != CMD_NOP);
    assign err_now = ck_rise & par_en & (^{ca_s, par_s});

    // with parity enabled commands wait the parity latency; an error drops the window around it
    always_comb
    begin
        next_pipe_vld = pipe_vld;
        next_pipe_err = pipe_err;
        next_pipe_cmd = pipe_cmd;
        next_blk_cnt = blk_cnt;
        next_exec_valid = 1'b0;
        next_exec_cmd = exec_cmd;
        par_trig = 1'b0;
        if (ck_rise)
        begin
            next_pipe_vld = {pipe_vld[PL_NCK-2:0], in_vld && par_en && blk_cnt == 3'h0};
            next_pipe_err = {pipe_err[PL_NCK-2:0], err_now};
            next_pipe_cmd = {pipe_cmd[3*PL_NCK-4:0], in_cmd};
            if (blk_cnt != 3'h0)
                next_blk_cnt = blk_cnt - 3'h1;
            if (err_now)
            begin
                next_pipe_vld = '0;
                next_blk_cnt = 3'(PL_NCK);
            end
            par_trig = pipe_err[PL_NCK-1];
            if (par_en && pipe_vld[PL_NCK-1] && !err_now)
            begin
                next_exec_valid = 1'b1;
                next_exec_cmd = dalg_cmd_e'(pipe_cmd[3*PL_NCK-1 -: 3]);
            end
            else if (!par_en && in_vld)
            begin
                next_exec_valid = 1'b1;
                next_exec_cmd = in_cmd;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pipe_vld <= '0;
            pipe_err <= '0;
            pipe_cmd <= '0;
            blk_cnt <= 3'h0;
            exec_valid <= 1'b0;
            exec_cmd <= CMD_DES;
        end
        else
        begin
            pipe_vld <= next_pipe_vld;
            pipe_err <= next_pipe_err;
            pipe_cmd <= next_pipe_cmd;
            blk_cnt <= next_blk_cnt;
            exec_valid <= next_exec_valid;
            exec_cmd <= next_exec_cmd;
        end
    end

    // -----------------------------------------------------------------------
    // alert pulses
    // -----------------------------------------------------------------------
    assign crc_trig = crc_en & wr_crc_err;

    dalg_pulse u_par_pulse (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .trig(par_trig),
        .tick(ck_rise),
        .len(ctrl[CTRL_FAST_BIN] ? PAR_PW_FAST_NCK : PAR_PW_SLOW_NCK),
        .active(par_act)
    );

    dalg_pulse u_crc_pulse (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .trig(crc_trig),
        .tick(ck_rise),
        .len(CRC_PW_NCK),
        .active(crc_act)
    );

    // one shared alert pin, low while either pulse runs
    assign alert_n = ~(par_act | crc_act);

    // -----------------------------------------------------------------------
    // internal write start
    // -----------------------------------------------------------------------
    logic [WQ_W-1:0] wq;
    logic [WQ_W-1:0] next_wq;
    logic [5:0] wr_pos;

    assign wr_pos = {1'b0, wlat} + (ctrl[CTRL_BC4_FIXED] ? WR_OFS_BC4 : WR_OFS_BL8) - 6'h01;

    // a marker walks down one place per clock edge
    always_comb
    begin
        next_wq = wq;
        if (ck_rise)
        begin
            next_wq = wq >> 1;
            if (next_exec_valid && next_exec_cmd == CMD_WR)
                next_wq[wr_pos] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wq <= '0;
        else
            wq <= next_wq;
    end

    assign wr_start = ck_rise & wq[0];

    // -----------------------------------------------------------------------
    // operations in progress and power-down
    // -----------------------------------------------------------------------
    logic [5:0] ref_cnt;
    logic [1:0] row_cnt;
    logic cke_q;
    logic pd;
    logic [5:0] next_ref_cnt;
    logic [1:0] next_row_cnt;
    logic next_cke_q;
    logic next_pd;
    logic [5:0] trfc;

    always_comb
    begin
        if (ctrl[CTRL_FGR_LSB +: 2] == FGR_1X)
            trfc = TRFC1_CYC;
        else if (ctrl[CTRL_FGR_LSB +: 2] == FGR_2X)
            trfc = TRFC2_CYC;
        else
            trfc = TRFC4_CYC;
    end

    assign busy = (ref_cnt != 6'h00) || (row_cnt != 2'h0);

    // low power only once row and refresh work has finished
    always_comb
    begin
        next_ref_cnt = ref_cnt;
        next_row_cnt = row_cnt;
        next_cke_q = cke_q;
        if (ref_cnt != 6'h00)
            next_ref_cnt = ref_cnt - 6'h01;
        if (ck_rise && row_cnt != 2'h0)
            next_row_cnt = row_cnt - 2'h1;
        if (next_exec_valid && next_exec_cmd == CMD_REF)
            next_ref_cnt = trfc;
        if (next_exec_valid && (next_exec_cmd == CMD_ACT || next_exec_cmd == CMD_PRE))
            next_row_cnt = ROW_BUSY_NCK;
        if (ck_rise)
            next_cke_q = cke_s;
        next_pd = ~cke_q & ~busy;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ref_cnt <= 6'h00;
            row_cnt <= 2'h0;
            cke_q <= 1'b1;
            pd <= 1'b0;
        end
        else
        begin
            ref_cnt <= next_ref_cnt;
            row_cnt <= next_row_cnt;
            cke_q <= next_cke_q;
            pd <= next_pd;
        end
    end

    assign pdown = pd;

    // -----------------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------------
    logic [7:0] par_ticks;
    logic [7:0] crc_ticks;

    // command clock edges seen while each pulse runs
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            par_ticks <= 8'h00;
            crc_ticks <= 8'h00;
        end
        else
        begin
            par_ticks <= !par_act ? 8'h00 : par_ticks + {7'h00, ck_rise};
            crc_ticks <= !crc_act ? 8'h00 : crc_ticks + {7'h00, ck_rise};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_par_alert_on: assert property (par_trig |=> !alert_n) else $error("parity alert late");
    a_par_pulse_len: assert property ($fell(par_act) && !$past(par_trig) |->
        $past(par_ticks) >= (ctrl[CTRL_FAST_BIN] ? 95 : 87) &&
        $past(par_ticks) <= (ctrl[CTRL_FAST_BIN] ? PAR_PW_FAST_MAX_NCK : PAR_PW_SLOW_MAX_NCK))
        else $error("parity alert width");
    a_crc_alert_on: assert property (crc_trig |-> ##1 !alert_n) else $error("crc alert late");
    a_crc_pulse_len: assert property ($fell(crc_act) && !$past(crc_trig) |->
        $past(crc_ticks) >= CRC_PW_MIN_NCK - 1 && $past(crc_ticks) <= CRC_PW_MAX_NCK)
        else $error("crc alert width");
    a_par_flush: assert property (err_now |=> pipe_vld == '0 ##1 !exec_valid) else $error("window not flushed");
    a_par_block: assert property (ck_rise && blk_cnt != 3'h0 |=> !pipe_vld[0]) else $error("blocked cmd kept");
    a_wr_mark: assert property (exec_valid && exec_cmd == CMD_WR && $past(ck_rise) |->
        wq[$past(wr_pos)]) else $error("write start lost");
    a_pd_busy: assert property (busy |=> !pdown) else $error("power-down while busy");
    a_ref_hold: assert property (exec_valid && exec_cmd == CMD_REF |-> busy [*8]) else $error("refresh too short");
    a_rd_unmapped: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0) else $error("bad read");

    c_par_alert: cover property (par_trig ##1 !alert_n);
    c_crc_alert: cover property (crc_trig ##1 !alert_n);
    c_wr_start: cover property (wr_start);
    c_pdown: cover property ($rose(pdown));

endmodule : dalg_top

`default_nettype wire

/* File: core/dalg_pkg.sv */
// ---------------------------------------------------------------------------
// shared constants of the alert and timing block
// ---------------------------------------------------------------------------
package dalg_pkg;

    // reference clock
    localparam int CLK_PERIOD_NS = 8;

    // command/address parity
    localparam int PL_NCK = 6;
    localparam logic [7:0] PAR_PW_SLOW_NCK = 8'h58;  // 88 clocks, slower bin
    localparam logic [7:0] PAR_PW_FAST_NCK = 8'h60;  // 96 clocks, faster bin
    localparam int PAR_PW_SLOW_MAX_NCK = 176;
    localparam int PAR_PW_FAST_MAX_NCK = 192;
    localparam int PAR_ALERT_ON_NS = 6;

    // write crc alert
    localparam int CRC_ALERT_MIN_NS = 3;
    localparam int CRC_ALERT_MAX_NS = 13;
    localparam int CRC_ALERT_DLY = (CRC_ALERT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (CRC_ALERT_MAX_NS / CLK_PERIOD_NS);
    localparam logic [7:0] CRC_PW_NCK = 8'h08;
    localparam int CRC_PW_MIN_NCK = 6;
    localparam int CRC_PW_MAX_NCK = 10;

    // refresh cycle times, rounded up to reference cycles
    localparam int TRFC1_NS = 350;
    localparam int TRFC2_NS = 260;
    localparam int TRFC4_NS = 160;
    localparam logic [5:0] TRFC1_CYC = 6'((TRFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] TRFC2_CYC = 6'((TRFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] TRFC4_CYC = 6'((TRFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // row operation occupancy in command clocks
    localparam logic [1:0] ROW_BUSY_NCK = 2'h2;

    // internal write start offsets after write latency
    localparam logic [5:0] WR_OFS_BL8 = 6'h04;
    localparam logic [5:0] WR_OFS_BC4 = 6'h02;
    localparam int WQ_W = 40;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WLAT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ERRCNT = 8'h0c;

    // control fields
    localparam int CTRL_PAR_EN = 0;
    localparam int CTRL_CRC_EN = 1;
    localparam int CTRL_BC4_FIXED = 2;
    localparam int CTRL_FAST_BIN = 3;
    localparam int CTRL_FGR_LSB = 4;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [4:0] WLAT_RST = 5'h09;

    // status fields
    localparam int ST_PAR_ERR = 0;
    localparam int ST_CRC_ERR = 1;
    localparam int ST_ALERT = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_PDOWN = 4;

    // refresh granularity
    localparam logic [1:0] FGR_1X = 2'h0;
    localparam logic [1:0] FGR_2X = 2'h1;

    // decoded command on ca[2:0]
    typedef enum logic [2:0] {
        CMD_DES = 3'h0,
        CMD_ACT = 3'h1,
        CMD_PRE = 3'h2,
        CMD_REF = 3'h3,
        CMD_WR = 3'h4,
        CMD_RD = 3'h5,
        CMD_MRS = 3'h6,
        CMD_NOP = 3'h7
    } dalg_cmd_e;

endpackage : dalg_pkg

/* File: core/dalg_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// two-flop synchroniser, one per bit
// ---------------------------------------------------------------------------
module dalg_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta;
            // first flop feeds only the second
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    meta <= 1'b0;
                    dout[i] <= 1'b0;
                end
                else
                begin
                    meta <= din[i];
                    dout[i] <= meta;
                end
            end
        end
    endgenerate

endmodule : dalg_sync

`default_nettype wire

/* File: core/dalg_pulse.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// pulse stretcher counted in command clock edges
// ---------------------------------------------------------------------------
module dalg_pulse (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // trigger, command clock edge and length
    input wire logic trig,
    input wire logic tick,
    input wire logic [7:0] len,
    // pulse
    output logic active
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;

    // load on trigger, count down on each edge
    always_comb
    begin
        next_cnt = cnt;
        if (trig)
            next_cnt = len;
        else if (tick && cnt != 8'h00)
            next_cnt = cnt - 8'h01;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt <= 8'h00;
        else
            cnt <= next_cnt;
    end

    assign active = (cnt != 8'h00);

endmodule : dalg_pulse

`default_nettype wire

/* File: dv/dalg_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// controller model: command clock, clock enable, command pins
// ---------------------------------------------------------------------------
module dalg_ctrl_model
    import dalg_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // pins toward the device
    output logic ck,
    output logic cke,
    output logic [7:0] ca,
    output logic ca_par
);
    int now = 0;
    int t_cmd = 0;
    int trfc_ns = TRFC1_NS;
    int gap = 0;
    logic [4:0] ph = 5'h00;
    // leveling entry spacing, update and reset-exit delays are plain defaults
    localparam int WLMRD_NCK = 40;
    localparam int WLDQSEN_NCK = 25;
    localparam int MOD_NCK = 30;
    localparam int XPR_NCK = 8;
    localparam int WL_MAX_NCK = 31; // longest programmable write latency
    int twr_ns = 15; // recovery, plain default
    int twr_crc_dm_ns = 20; // crc-with-mask recovery, plain default
    logic crc_dm = 1'b0;
    int wpd = 0;
    // pin levels at time zero
    initial
    begin
        ck = 1'b0;
        cke = 1'b1;
        ca = 8'h00;
        ca_par = 1'b0;
    end
    // free-running command clock of twenty reference cycles
    always @(posedge ref_clk)
    begin
        now <= now + 1;
        ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
        ck <= ph < 5'h0a;
        if (ph == 5'h00 && gap != 0)
            gap <= gap - 1;
        if (ph == 5'h00 && wpd != 0)
            wpd <= wpd - 1;
    end
    // one command on a falling edge, deselect one clock later
    // reads never issued, no locked delay loop needed
    task automatic send(input dalg_cmd_e c, input logic bad, input logic ke);
        while (!ke && wpd != 0)
            @(posedge ref_clk);
        while ((c == CMD_ACT || c == CMD_REF) && gap != 0)
            @(posedge ref_clk);
        @(posedge ref_clk iff ph == 5'h0a);
        ca <= {5'h00, c};
        ca_par <= (^c) ^ bad;
        t_cmd = now;
        if (c == CMD_REF)
            gap <= (trfc_ns + 159) / 160;
        if (c == CMD_WR)
            wpd <= WL_MAX_NCK + 4 + ((crc_dm ? twr_crc_dm_ns : twr_ns) + 159) / 160;
        @(posedge ref_clk iff ph == 5'h0a);
        ca <= 8'h00;
        ca_par <= 1'b0;
        cke <= ke;
    endtask : send
    // mode setup: reset exit, leveling entry, geardown sync and first command spacing
    task automatic mode_seq;
        repeat (XPR_NCK) @(posedge ck);
        send(CMD_MRS, 1'b0, 1'b1);
        repeat (WLDQSEN_NCK) @(posedge ck);
        repeat (WLMRD_NCK - WLDQSEN_NCK) @(posedge ck);
        repeat (MOD_NCK + 4) @(posedge ck);
        repeat (MOD_NCK) @(posedge ck);
    endtask : mode_seq
endmodule : dalg_ctrl_model
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// register, command and alert checks
// ---------------------------------------------------------------------------
module testbench;
    import dalg_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wr_crc_err = 1'b0;
    logic [31:0] reg_rdata;
    logic ck;
    logic cke;
    logic [7:0] ca;
    logic ca_par;
    logic alert_n;
    logic exec_valid;
    dalg_cmd_e exec_cmd;
    dalg_cmd_e last_cmd;
    logic wr_start;
    logic pdown;
    logic al_prev = 1'b1;
    logic pd_prev = 1'b0;
    int evc[5] = '{default: 0};
    int evt[5] = '{default: 0};
    int rfc_ns[3] = '{350, 260, 160};
    int bad_count = 0;
    int checks = 0;
    int o, t0, k, cyc, lo;

    dalg_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ck(ck), .cke(cke), .ca(ca), .ca_par(ca_par), .alert_n(alert_n),
        .wr_crc_err(wr_crc_err), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
        .wr_start(wr_start), .pdown(pdown));
    dalg_ctrl_model model (.ref_clk(ref_clk), .ck(ck), .cke(cke), .ca(ca), .ca_par(ca_par));

    // reference clock
    always #4 ref_clk = ~ref_clk;

    // event counts and times: execute, write start, alert rise, power down; alert fall time only
    always @(posedge ref_clk)
    begin
        if (exec_valid === 1'b1)
        begin
            evc[0]++;
            evt[0] = model.now;
            last_cmd = exec_cmd;
        end
        if (wr_start === 1'b1)
        begin
            evc[1]++;
            evt[1] = model.now;
        end
        if (alert_n === 1'b0 && al_prev === 1'b1)
            evt[2] = model.now;
        if (alert_n === 1'b1 && al_prev === 1'b0)
        begin
            evc[3]++;
            evt[3] = model.now;
        end
        if (pdown === 1'b1 && pd_prev === 1'b0)
        begin
            evc[4]++;
            evt[4] = model.now;
        end
        al_prev = alert_n;
        pd_prev = pdown;
    end

    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    task automatic inr(input string nm, input int v, input int l, input int h);
        chk(nm, 32'(v >= l && v <= h), 32'h1);
    endtask : inr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(nm, reg_rdata, e);
    endtask : rchk

    task automatic till(input int w, input int old);
        int i;
        for (i = 0; i < 4000 && evc[w] == old; i++)
            @(posedge ref_clk);
        if (evc[w] == old)
        begin
            bad_count++;
            results();
        end
    endtask : till

    // main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rchk("ctrl", REG_CTRL, 32'h0);
        rchk("wlat", REG_WLAT, 32'h9);
        wr(8'h01, 32'hffffffff);
        rchk("unmapped", 8'h01, 32'h0);
        model.mode_seq();
        o = evc[0];
        model.send(CMD_ACT, 1'b0, 1'b1);
        till(0, o);
        inr("exec lat", evt[0] - model.t_cmd, 8, 20);
        wr(REG_CTRL, 32'h1);
        o = evc[0];
        model.send(CMD_WR, 1'b0, 1'b1);
        till(0, o);
        inr("par lat", evt[0] - model.t_cmd, 128, 140);
        chk("exec cmd", 32'(last_cmd), 32'(CMD_WR));
        for (k = 0; k < 2; k++)
        begin
            wr(REG_CTRL, k ? 32'h9 : 32'h1);
            o = evc[0];
            lo = evc[3];
            model.send(CMD_PRE, 1'b1, 1'b1);
            t0 = model.t_cmd;
            model.send(CMD_ACT, 1'b0, 1'b1);
            till(3, lo);
            chk("dropped", 32'(evc[0] - o), 32'h0);
            inr("par alert on", evt[2] - t0, 128, 140);
            inr("par alert pw", evt[3] - evt[2], (k ? 96 : 88) * 20 - 20, (k ? 96 : 88) * 20 + 20);
        end
        rchk("status par", REG_STATUS, 32'h1);
        rchk("errcnt par", REG_ERRCNT, 32'h2);
        wr(REG_STATUS, 32'h3);
        wr(REG_ERRCNT, 32'h0);
        rchk("errcnt clr", REG_ERRCNT, 32'h0);
        wr(REG_CTRL, 32'h2);
        lo = evc[3];
        @(posedge ref_clk);
        wr_crc_err <= 1'b1;
        t0 = model.now;
        @(posedge ref_clk);
        wr_crc_err <= 1'b0;
        till(3, lo);
        inr("crc alert on", evt[2] - t0, 1, 2);
        inr("crc alert pw", evt[3] - evt[2], 120, 200);
        rchk("status crc", REG_STATUS, 32'h2);
        rchk("errcnt crc", REG_ERRCNT, 32'h10000);
        wr(REG_STATUS, 32'h3);
        wr(REG_WLAT, 32'hc);
        for (k = 0; k < 2; k++)
        begin
            wr(REG_CTRL, k ? 32'h4 : 32'h0);
            model.crc_dm = (k == 1);
            o = evc[1];
            model.send(CMD_WR, 1'b0, 1'b1);
            till(1, o);
            lo = (k ? 14 : 16) * 20;
            inr("wr start", evt[1] - model.t_cmd, lo + 8, lo + 20);
        end
        for (k = 0; k < 3; k++)
        begin
            wr(REG_CTRL, 32'(k) << 4);
            model.trfc_ns = rfc_ns[k];
            cyc = (rfc_ns[k] + 7) / 8;
            o = evc[4];
            model.send(CMD_REF, 1'b0, 1'b0);
            till(4, o);
            lo = (cyc > 21) ? cyc + 13 : 34;
            inr("pdown", evt[4] - model.t_cmd, cyc + 12, lo + 8);
            rchk("status pd", REG_STATUS, 32'h10);
            model.send(CMD_DES, 1'b0, 1'b1);
        end
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rchk("wlat again", REG_WLAT, 32'h9);
        results();
    end
endmodule : testbench
`default_nettype wire
